// File: hdl/sync_serial_port.v
// Synchronous serial port: master or slave shifter between two word FIFOs.
`timescale 1ns/1ps
`include "sync_serial_port_consts.vh"
module sync_serial_port (
  input wire core_clk_in,
  input wire reset_in,
  input wire enable_in,
  input wire master_in,
  input wire out_disable_in,
  input wire [1:0] format_in,
  input wire [4:0] frame_bits_in,
  input wire [7:0] prescale_in,
  input wire [7:0] bit_div_in,
  input wire [15:0] tx_data_in,
  input wire tx_valid_in,
  output reg tx_ready_out,
  output reg [15:0] rx_data_out,
  output reg rx_valid_out,
  input wire rx_ready_in,
  output reg [3:0] tx_level_out,
  output reg [3:0] rx_level_out,
  output reg busy_out,
  output reg sclk_out,
  output reg sclk_oe_out,
  input wire sclk_in,
  output reg frame_out,
  output reg frame_oe_out,
  input wire frame_in,
  output reg txd_out,
  output reg txd_oe_out,
  input wire rxd_in
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  reg [2:0] state_reg;
  reg [7:0] pre_cnt_reg;
  reg [7:0] div_cnt_reg;
  reg phase_reg;
  reg [4:0] bit_cnt_reg;
  reg [4:0] len_reg;
  reg [15:0] tx_sh_reg;
  reg [15:0] rx_sh_reg;
  reg sclk_d_reg;
  reg frame_d_reg;
  reg rx_push_reg;
  wire [15:0] txf_data;
  wire txf_valid;
  wire txf_ready;
  wire rxf_ready;
  wire [15:0] rxf_data;
  wire rxf_valid;
  wire [3:0] txf_level;
  wire [3:0] rxf_level;
  wire tick;
  wire rise;
  wire fall;
  wire [4:0] eff_len;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clamp a programmed frame length into the legal range.
  function [4:0] clamp_len;
    input [4:0] n;
    begin
      if (n < `SSP_SIZE_MIN) begin
        clamp_len = `SSP_SIZE_MIN;
      end else if (n > `SSP_SIZE_MAX) begin
        clamp_len = `SSP_SIZE_MAX;
      end else begin
        clamp_len = n;
      end
    end
  endfunction
  assign eff_len = clamp_len(frame_bits_in); // see (R3)
  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  // Transmit FIFO fed by the user, drained by the shifter in master mode only.
  ssp_fifo u_tx_fifo ( // see (R5)
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .wr_data_in(tx_data_in),
    .wr_valid_in(tx_valid_in && tx_ready_out),
    .wr_ready_out(txf_ready),
    .rd_data_out(txf_data),
    .rd_valid_out(txf_valid),
    .rd_ready_in(state_reg == ST_IDLE && enable_in && master_in),
    .level_out(txf_level)
  );
  // Receive FIFO fed by the shifter; a full FIFO with a stalled reader drops the newest word.
  ssp_fifo u_rx_fifo ( // see (R5)
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .wr_data_in(rx_sh_reg),
    .wr_valid_in(rx_push_reg),
    .wr_ready_out(rxf_ready),
    .rd_data_out(rxf_data),
    .rd_valid_out(rxf_valid),
    .rd_ready_in(!rx_valid_out || rx_ready_in),
    .level_out(rxf_level)
  );
  // ----------------------------------------
  // Clock generation and edge detection
  // ----------------------------------------
  // Master bit clock: prescaler then bit divider; each tick toggles the serial clock phase.
  assign tick = (pre_cnt_reg == 8'h00) && (div_cnt_reg == 8'h00); // see (R8)
  assign rise = master_in ? (tick && !phase_reg) : (sclk_in && !sclk_d_reg); // see (R6)
  assign fall = master_in ? (tick && phase_reg) : (!sclk_in && sclk_d_reg);
  // ----------------------------------------
  // Shifter and frame control
  // ----------------------------------------
  // Data changes on falling edges and is sampled on rising edges in every format.
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      pre_cnt_reg <= 8'h00;
      div_cnt_reg <= 8'h00;
      phase_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      len_reg <= 5'h04;
      tx_sh_reg <= 16'h0000;
      rx_sh_reg <= 16'h0000;
      sclk_d_reg <= 1'b0;
      frame_d_reg <= 1'b1;
      rx_push_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_in;
      frame_d_reg <= frame_in;
      rx_push_reg <= 1'b0;
      if (state_reg == ST_IDLE || pre_cnt_reg == 8'h00) begin
        pre_cnt_reg <= prescale_in; // see (R8)
      end else begin
        pre_cnt_reg <= pre_cnt_reg - 8'h01;
      end
      if (state_reg == ST_IDLE) begin
        div_cnt_reg <= bit_div_in;
      end else if (pre_cnt_reg == 8'h00) begin
        div_cnt_reg <= (div_cnt_reg == 8'h00) ? bit_div_in : div_cnt_reg - 8'h01; // see (R8)
      end
      if (tick && state_reg != ST_IDLE) begin
        phase_reg <= !phase_reg;
      end
      case (state_reg)
        ST_IDLE: begin
          phase_reg <= 1'b0;
          bit_cnt_reg <= 5'h00;
          len_reg <= eff_len;
          // Clearing here keeps bits of an earlier, longer frame out of the next word.
          rx_sh_reg <= 16'h0000; // see (R4)
          if (enable_in && master_in && txf_valid) begin
            tx_sh_reg <= txf_data << (5'h10 - eff_len); // see (R4)
            state_reg <= ST_SHIFT;
          end else if (enable_in && !master_in && !frame_in && frame_d_reg) begin
            tx_sh_reg <= txf_valid ? txf_data << (5'h10 - eff_len) : 16'h0000;
            state_reg <= ST_SHIFT; // see (R9)
          end
        end
        ST_SHIFT: begin
          if (rise) begin
            rx_sh_reg <= {rx_sh_reg[14:0], rxd_in}; // see (R4)
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
          if (fall) begin
            tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
            if (bit_cnt_reg == len_reg) begin
              state_reg <= ST_DONE;
            end
          end
          if (!enable_in || (!master_in && frame_in)) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          rx_push_reg <= rxf_ready && (bit_cnt_reg == len_reg);
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Pin drive follows role, format and the slave output disable.
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sclk_out <= 1'b0;
      sclk_oe_out <= 1'b0;
      frame_out <= 1'b1;
      frame_oe_out <= 1'b0;
      txd_out <= 1'b0;
      txd_oe_out <= 1'b0;
      tx_ready_out <= 1'b0;
      rx_data_out <= 16'h0000;
      rx_valid_out <= 1'b0;
      tx_level_out <= 4'h0;
      rx_level_out <= 4'h0;
      busy_out <= 1'b0;
    end else begin
      sclk_out <= (state_reg == ST_SHIFT) && phase_reg; // see (R1)
      sclk_oe_out <= master_in && enable_in; // see (R6)
      case (format_in) // see (R2)
        `SSP_FMT_SSF: frame_out <= !((state_reg == ST_IDLE) && master_in && txf_valid);
        `SSP_FMT_CMD: frame_out <= (state_reg == ST_IDLE);
        default: frame_out <= (state_reg == ST_IDLE);
      endcase
      frame_oe_out <= master_in && enable_in;
      txd_out <= tx_sh_reg[15];
      if (master_in) begin
        // Command format sends only the command bits; afterwards the line is released.
        txd_oe_out <= enable_in && !((format_in == `SSP_FMT_CMD) && (bit_cnt_reg >= `SSP_CMD_BITS)
          && (state_reg == ST_SHIFT)); // see (R2)
      end else begin
        txd_oe_out <= enable_in && !out_disable_in && (state_reg == ST_SHIFT); // see (R7)
      end
      tx_ready_out <= txf_ready && !(tx_valid_in && tx_ready_out && txf_level == 4'h7);
      if (!rx_valid_out || rx_ready_in) begin
        rx_valid_out <= rxf_valid;
        rx_data_out <= rxf_data;
      end
      tx_level_out <= txf_level;
      rx_level_out <= rxf_level;
      busy_out <= (state_reg != ST_IDLE) || txf_valid;
    end
  end
endmodule // sync_serial_port

// File: include/sync_serial_port_consts.vh
// Constants shared by the synchronous serial port design files.
// Operation
// (R1) The port talks to its peripheral over four wires: serial clock, frame or select, data out and data in.
// (R2) Three frame formats are selectable: SPI style, three-wire command and response, and synchronous serial frame.
// (R3) The frame length is programmable from 4 to 16 bits, both limits included.
// (R4) Incoming serial bits are gathered into parallel words and queued words are shifted out on the data line.
// (R5) Transmit and receive paths each have their own FIFO of eight 16-bit words.
// (R6) The port works either as master, making clock and frame timing, or as slave following an external master.
// (R7) As a slave the port can keep its data output undriven so several slaves can share one receive line.
// (R8) As master the serial clock comes from the input clock through a prescaler and then a bit-rate divider.
// (R9) As slave the external master supplies clock and frame and keeps its bit rate within what the port can sample.
`ifndef SYNC_SERIAL_PORT_CONSTS_VH
`define SYNC_SERIAL_PORT_CONSTS_VH
// ----------------------------------------
// Word and FIFO geometry
// ----------------------------------------
`define SSP_WORD_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_FIFO_AW 3
`define SSP_FIFO_CW 4
// ----------------------------------------
// Frame formats and size limits
// ----------------------------------------
`define SSP_FMT_SPI 2'h0
`define SSP_FMT_CMD 2'h1
`define SSP_FMT_SSF 2'h2
`define SSP_SIZE_MIN 5'h04
`define SSP_SIZE_MAX 5'h10
`define SSP_CMD_BITS 5'h08
`endif

// File: hdl/ssp_fifo.v
// Eight-word FIFO with registered read data and valid/ready on both sides.
`timescale 1ns/1ps
`include "sync_serial_port_consts.vh"
module ssp_fifo (
  input wire core_clk_in,
  input wire reset_in,
  input wire [`SSP_WORD_W-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output reg [`SSP_WORD_W-1:0] rd_data_out,
  output reg rd_valid_out,
  input wire rd_ready_in,
  output wire [`SSP_FIFO_CW-1:0] level_out
);
  reg [`SSP_WORD_W-1:0] mem_reg [0:`SSP_FIFO_DEPTH-1];
  reg [`SSP_FIFO_AW-1:0] wr_ptr_reg;
  reg [`SSP_FIFO_AW-1:0] rd_ptr_reg;
  reg [`SSP_FIFO_CW-1:0] count_reg;
  wire push;
  wire pop;
  wire load;
  // ----------------------------------------
  // Handshake terms
  // ----------------------------------------
  // A word moves from the array to the output register when that register is free.
  assign wr_ready_out = (count_reg != `SSP_FIFO_DEPTH);
  assign push = wr_valid_in && wr_ready_out;
  assign load = (count_reg != 4'h0) && (!rd_valid_out || rd_ready_in);
  assign pop = rd_valid_out && rd_ready_in;
  assign level_out = count_reg;
  // Storage array write port.
  always @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end
  // Pointers, count and the registered output stage.
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
      count_reg <= 4'h0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 16'h0000;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 3'h1;
      end
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + 3'h1;
        rd_data_out <= mem_reg[rd_ptr_reg];
        rd_valid_out <= 1'b1;
      end else if (pop) begin
        rd_valid_out <= 1'b0;
      end
      count_reg <= count_reg + {3'h0, push} - {3'h0, load};
    end
  end
endmodule // ssp_fifo

// File: tb/sync_serial_port_sva.sv
// Checker of the port's pins and word handshakes.
`timescale 1ns/1ps
`include "sync_serial_port_consts.vh"
module sync_serial_port_sva (
  input wire core_clk_in, reset_in, master_in, out_disable_in, rx_ready_in,
  input wire [1:0] format_in,
  input wire [4:0] frame_bits_in,
  input wire [7:0] prescale_in, bit_div_in,
  input wire tx_ready_out, rx_valid_out, busy_out, sclk_out, sclk_oe_out,
  input wire frame_out, frame_oe_out, txd_oe_out,
  input wire [15:0] rx_data_out,
  input wire [3:0] tx_level_out
);
  // ----------------------------------------
  // Half-bit timer and rising-edge counter.
  // ----------------------------------------
  reg [15:0] cnt_reg;
  reg [4:0] nb_reg;
  reg seen_reg, sq_reg, fq_reg;
  wire tog = sclk_out != sq_reg;
  wire fch = frame_out != fq_reg;
  wire [15:0] half = (prescale_in + 16'h1) * (bit_div_in + 16'h1);
  wire [4:0] len = frame_bits_in < 5'h04 ? 5'h04 : (frame_bits_in > 5'h10 ? 5'h10 : frame_bits_in);
  // Counts cycles between clock toggles and rises within a frame.
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= 16'h0; nb_reg <= 5'h0; seen_reg <= 1'b0; sq_reg <= 1'b0; fq_reg <= 1'b1;
    end else begin
      sq_reg <= sclk_out; fq_reg <= frame_out;
      cnt_reg <= tog ? 16'h1 : cnt_reg + 16'h1;
      seen_reg <= fch ? 1'b0 : (tog | seen_reg);
      nb_reg <= fch ? 5'h0 : nb_reg + {4'h0, tog & sclk_out};
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  a_reset_idle_pins: assert property ($fell(reset_in) |-> frame_out && !busy_out && !txd_oe_out)
    else $error("pins not idle after reset");
  a_slave_quiet_out: assert property ((!master_in && out_disable_in)[*3] |-> !txd_oe_out)
    else $error("slave drives data while disabled");
  a_slave_no_clock: assert property ((!master_in)[*3] |-> !sclk_oe_out && !frame_oe_out)
    else $error("slave drives clock or frame");
  a_full_tx_refuse: assert property (tx_level_out == 4'h8 |-> !tx_ready_out)
    else $error("full transmit buffer accepts");
  a_half_bit_time: assert property (tog && seen_reg && master_in |-> cnt_reg == half)
    else $error("half-bit time wrong");
  a_rx_word_holds: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
    else $error("receive word lost while stalled");
  a_spi_clock_idle: assert property ((frame_out && master_in && format_in == `SSP_FMT_SPI)[*2] |-> !sclk_out)
    else $error("clock not idle low between frames");
  a_frame_bit_count: assert property ($rose(frame_out) && master_in && format_in == `SSP_FMT_SPI |-> nb_reg == len)
    else $error("frame length wrong");
  c_frame_done: cover property ($rose(frame_out) && master_in);
  c_tx_full: cover property (tx_level_out == 4'h8);
  c_rx_stall: cover property (rx_valid_out && !rx_ready_in);
endmodule // sync_serial_port_sva
bind sync_serial_port sync_serial_port_sva i_sync_serial_port_sva (.core_clk_in, .reset_in, .master_in,
  .out_disable_in, .rx_ready_in, .format_in, .frame_bits_in, .prescale_in, .bit_div_in, .tx_ready_out,
  .rx_valid_out, .busy_out, .sclk_out, .sclk_oe_out, .frame_out, .frame_oe_out, .txd_oe_out,
  .rx_data_out, .tx_level_out);

// File: tb/ssp_peer.sv
// Serial peripheral model that answers each frame from a shift register.
`timescale 1ns/1ps
module ssp_peer (
  input wire sclk_in, frame_in, txd_in,
  input wire [4:0] bits_in,
  input wire [15:0] word_in,
  output reg rxd_out,
  output reg [15:0] got_out
);
  reg [15:0] sh_reg = 16'h0;
  reg [4:0] cnt_reg = 5'h10;
  initial rxd_out = 1'b0;
  initial got_out = 16'h0;
  // Loads the answer at frame start and shows its top bit first.
  always @(negedge frame_in) begin
    sh_reg = word_in << (5'h10 - bits_in);
    cnt_reg = 5'h0;
    got_out = 16'h0;
    rxd_out = sh_reg[15];
  end
  // Captures on the rising clock edge.
  always @(posedge sclk_in) if (cnt_reg < bits_in) begin
    got_out = {got_out[14:0], txd_in};
    cnt_reg = cnt_reg + 5'h1;
  end
  // Shifts on the falling edge; once done the line shows no stale bit.
  always @(negedge sclk_in) begin
    sh_reg = sh_reg << 1;
    rxd_out = (cnt_reg < bits_in) ? sh_reg[15] : ~rxd_out;
  end
endmodule // ssp_peer

// File: tb/test_sync_serial_port.sv
// Self-checking bench for the synchronous serial port.
`timescale 1ns/1ps
`include "sync_serial_port_consts.vh"
module test_sync_serial_port;
  reg clk = 1'b0, rst = 1'b1, master = 1'b1, odis = 1'b0, tv = 1'b0, rr = 1'b1;
  reg [1:0] fmt = 2'h0;
  reg [4:0] nb = 5'h08, pn = 5'h08;
  reg [7:0] pre = 8'h00, bdiv = 8'h01;
  reg [15:0] td = 16'h0, pw = 16'h0;
  integer n_errors = 0, checks = 0;
  wire tr, rv, busy, sco, sc, fo, foe, to, toe, rxd;
  wire [15:0] rd, got;
  wire [3:0] tl, rl;
  wire sclk = sco ? sc : 1'b0;
  wire fr = foe ? fo : 1'b1;
  always #2 clk = ~clk;
  sync_serial_port i_sync_serial_port (.core_clk_in(clk), .reset_in(rst), .enable_in(1'b1),
    .master_in(master), .out_disable_in(odis), .format_in(fmt), .frame_bits_in(nb),
    .prescale_in(pre), .bit_div_in(bdiv), .tx_data_in(td), .tx_valid_in(tv), .tx_ready_out(tr),
    .rx_data_out(rd), .rx_valid_out(rv), .rx_ready_in(rr), .tx_level_out(tl), .rx_level_out(rl),
    .busy_out(busy), .sclk_out(sc), .sclk_oe_out(sco), .sclk_in(sclk), .frame_out(fo),
    .frame_oe_out(foe), .frame_in(fr), .txd_out(to), .txd_oe_out(toe), .rxd_in(rxd));
  ssp_peer i_ssp_peer (.sclk_in(sclk), .frame_in(fr), .txd_in(to), .bits_in(pn), .word_in(pw),
    .rxd_out(rxd), .got_out(got));
  task chk(input ok);
    begin
      checks = checks + 1;
      if (!ok) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: value mismatch", $time);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // One master frame each way, compared on both ends.
  task frm(input [1:0] f, input [4:0] b, input [15:0] w, input [15:0] p);
    integer i;
    reg [15:0] m;
    begin
      pn = b < 5'h04 ? 5'h04 : (b > 5'h10 ? 5'h10 : b);
      m = (17'h1 << pn) - 17'h1;
      fmt = f; nb = b; pw = p; td = w; tv = 1'b1;
      while (tr !== 1'b1) @(negedge clk);
      @(negedge clk);
      tv = 1'b0;
      i = 0;
      while (rv !== 1'b1 && i < 3000) begin @(negedge clk); i = i + 1; end
      chk(rd === (p & m));
      chk(got === (w & m));
      @(negedge clk);
      $display("frame test format %0d bits %0d done", f, b);
    end
  endtask
  // Fills the transmit buffer while the receiver stalls, then drains.
  task fifo_fill;
    integer i, j, k;
    begin
      rr = 1'b0; pre = 8'h01; bdiv = 8'h03; fmt = `SSP_FMT_SPI; nb = 5'h04; pn = 5'h04; k = 0;
      for (i = 0; i < 20; i = i + 1) begin
        @(negedge clk);
        if (tr === 1'b1) begin tv = 1'b1; td = k; k = k + 1; end else tv = 1'b0;
      end
      @(negedge clk);
      tv = 1'b0;
      chk(tl === 4'h8);
      chk(k >= 9 && k <= 10);
      i = 0;
      while ((busy !== 1'b0 || tl !== 4'h0) && i < 5000) begin @(negedge clk); i = i + 1; end
      repeat (8) @(negedge clk);
      chk(rl === k - 2);
      rr = 1'b1; j = 0;
      for (i = 0; i < 20; i = i + 1) begin if (rv === 1'b1) j = j + 1; @(negedge clk); end
      chk(j == k);
      chk(rl === 4'h0);
      pre = 8'h00; bdiv = 8'h01;
      $display("buffer test done");
    end
  endtask
  // Slave with its output disabled drives none of the pins.
  task slave_quiet;
    begin
      master = 1'b0; odis = 1'b1;
      repeat (4) @(negedge clk);
      chk(toe === 1'b0 && sco === 1'b0 && foe === 1'b0);
      master = 1'b1; odis = 1'b0;
      repeat (4) @(negedge clk);
      $display("slave test done");
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    chk(fo === 1'b1 && toe === 1'b0 && tr === 1'b0);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(tr === 1'b1);
    frm(`SSP_FMT_SPI, 5'h04, 16'h000a, 16'h0005);
    frm(`SSP_FMT_SPI, 5'h10, 16'ha5c3, 16'h3c5a);
    frm(`SSP_FMT_SPI, 5'h03, 16'h0006, 16'h0009);
    frm(`SSP_FMT_SPI, 5'h11, 16'h9e21, 16'h61de);
    frm(`SSP_FMT_CMD, 5'h08, 16'h00b7, 16'h0049);
    frm(`SSP_FMT_SSF, 5'h0a, 16'h02d3, 16'h012c);
    fifo_fill;
    slave_quiet;
    summarize;
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #100000;
    n_errors = n_errors + 1;
    summarize;
  end
endmodule // test_sync_serial_port
